// *** rtl/eic_cfg.svh ***
// Offsets, fields, reset values, opcodes and counts of the execution core
//
// Functional notes
// - Pointer add sign-extends 6-bit literal, no flags
// - Indirect pointer wraps modulo 16 bits
// - AND literal into accumulator, zero flag only
// - Add literal into accumulator, C DC Z
// - File ops: 7-bit address, destination bit
// - Add accumulator and file, C DC Z
// - Arithmetic right shift, MSB kept, C Z
// - Add with carry, C DC Z
// - Bit clear/set by 3-bit index, no flags
// - Bit-test skip replaces next with no-op
// - Relative branch to PC+1+k, two cycles
// - Branch by accumulator to PC+1+W, two cycles
// - Call pushes PC+1, high latch fills top
// - Watchdog clear resets counters, sets both flags; a timeout in the same cycle still clears timeout_flag_n here
// - Call by accumulator, high latch bits 14:8
// - Complement/decrement file, zero flag only
// - Clears write zero and set zero flag
// - Decrement/increment skip on zero, no flags
// - Jump loads 11-bit literal, no push, two cycles
// - OR literal into accumulator, zero flag only
// - One 14-bit word per instruction
// - Four clock periods per instruction cycle
// - Extra cycle for indirect program-memory access
`ifndef EIC_CFG_SVH
`define EIC_CFG_SVH
// Register byte offsets
`define EIC_REG_CTRL 6'h00
`define EIC_REG_HLATCH 6'h04
`define EIC_REG_STATUS 6'h08
`define EIC_REG_ACC 6'h0c
`define EIC_REG_PC 6'h10
`define EIC_REG_PTR0 6'h14
`define EIC_REG_PTR1 6'h18
`define EIC_REG_WDOG 6'h1c
`define EIC_REG_STKTOP 6'h20
// Field positions
`define EIC_CTRL_RUN 0
`define EIC_ST_C 0
`define EIC_ST_DIG 1
`define EIC_ST_Z 2
`define EIC_ST_PWRN 3
`define EIC_ST_TOUTN 4
// Reset values
`define EIC_RST_PC 15'h0000
`define EIC_RST_FLAGN 1'b1
// Timing
`define EIC_PRESCALE_MAX 8'hff
`define EIC_STACK_DEPTH 16
// Opcode fields
`define EIC_OPC_BRANCH_ACC 14'h000b
`define EIC_OPC_CALL_ACC 14'h000a
`define EIC_OPC_WDOG_CLR 14'h0064
`define EIC_OPC_REL_BRANCH 5'h19
`define EIC_OPC_CALL 3'h4
`define EIC_OPC_JUMP 3'h5
`define EIC_OPC_PTR_ADD 7'h62
`define EIC_OPC_BIT_CLR 4'h4
`define EIC_OPC_BIT_SET 4'h5
`define EIC_OPC_SKIP_CLR 4'h6
`define EIC_OPC_SKIP_SET 4'h7
`define EIC_OPC_ADD_FILE 6'h07
`define EIC_OPC_ADDC_FILE 6'h3d
`define EIC_OPC_AND_FILE 6'h05
`define EIC_OPC_ASR_FILE 6'h37
`define EIC_OPC_CLEAR 6'h01
`define EIC_OPC_COMP_FILE 6'h09
`define EIC_OPC_DEC_FILE 6'h03
`define EIC_OPC_DEC_SKIP 6'h0b
`define EIC_OPC_INC_SKIP 6'h0f
`define EIC_OPC_ADD_LIT 6'h3e
`define EIC_OPC_AND_LIT 6'h39
`define EIC_OPC_OR_LIT 6'h38
`endif

// *** rtl/eic_pkg.sv ***
// Types shared by the execution core files
`default_nettype none
package eic_pkg;
	// Instruction cycle phases, one-hot
	typedef enum logic [3:0] {
		PH_ADDR = 4'b0001,
		PH_LATCH = 4'b0010,
		PH_READ = 4'b0100,
		PH_EXEC = 4'b1000
	} eic_phase_t;
	// Decoded operations
	typedef enum logic [4:0] {
		OP_NOP, OP_PTR_ADD, OP_AND_LIT, OP_ADD_LIT, OP_OR_LIT,
		OP_AND_FILE, OP_ADD_FILE, OP_ADDC_FILE, OP_ASR_FILE,
		OP_BIT_CLR, OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET,
		OP_REL_BRANCH, OP_BRANCH_ACC, OP_CALL, OP_CALL_ACC,
		OP_JUMP, OP_WDOG_CLR, OP_COMP_FILE, OP_CLR_FILE,
		OP_CLR_ACC, OP_DEC_FILE, OP_DEC_SKIP, OP_INC_SKIP
	} eic_op_t;
endpackage : eic_pkg
`default_nettype wire

// *** rtl/eic_alu.sv ***
// Arithmetic and logic unit of the execution core
`default_nettype none
module eic_alu (
	input wire eic_pkg::eic_op_t op,
	input wire logic [7:0] acc,
	input wire logic [7:0] fileVal,
	input wire logic [7:0] lit,
	input wire logic carryIn,
	input wire logic [2:0] bitSel,
	output logic [7:0] result,
	output logic carryOut,
	output logic digitOut,
	output logic zeroOut,
	output logic carryUpd,
	output logic digitUpd,
	output logic zeroUpd,
	output logic skipNext
);
	// One-hot mask of the selected bit
	function automatic logic [7:0] bitMask(input logic [2:0] sel);
		bitMask = 8'h01 << sel;
	endfunction : bitMask

	logic [7:0] addB; // Second adder operand
	logic addC; // Carry into the adder
	logic [8:0] sum; // Full sum with carry out
	logic [4:0] lowSum; // Low nibble sum for digit carry

	// Adder operand select
	always_comb begin
		addB = fileVal;
		addC = 1'b0;
		if (op == eic_pkg::OP_ADD_LIT) begin
			addB = lit;
		end
		if (op == eic_pkg::OP_ADDC_FILE) begin
			addC = carryIn;
		end
	end

	assign sum = {1'b0, acc} + {1'b0, addB} + {8'h00, addC};
	assign lowSum = {1'b0, acc[3:0]} + {1'b0, addB[3:0]} + {4'h0, addC};

	// Result and flag selection
	always_comb begin
		result = 8'h00;
		carryOut = carryIn;
		digitOut = lowSum[4];
		carryUpd = 1'b0;
		digitUpd = 1'b0;
		zeroUpd = 1'b0;
		skipNext = 1'b0;
		case (op)
			eic_pkg::OP_AND_LIT: begin
				result = acc & lit;
				zeroUpd = 1'b1;
			end
			eic_pkg::OP_OR_LIT: begin
				result = acc | lit;
				zeroUpd = 1'b1;
			end
			eic_pkg::OP_AND_FILE: begin
				result = acc & fileVal;
				zeroUpd = 1'b1;
			end
			eic_pkg::OP_ADD_LIT, eic_pkg::OP_ADD_FILE,
			eic_pkg::OP_ADDC_FILE: begin
				result = sum[7:0];
				carryOut = sum[8];
				{carryUpd, digitUpd, zeroUpd} = 3'h7;
			end
			eic_pkg::OP_ASR_FILE: begin
				result = {fileVal[7], fileVal[7:1]};
				carryOut = fileVal[0];
				carryUpd = 1'b1;
				zeroUpd = 1'b1;
			end
			eic_pkg::OP_BIT_CLR: result = fileVal & ~bitMask(bitSel);
			eic_pkg::OP_BIT_SET: result = fileVal | bitMask(bitSel);
			eic_pkg::OP_SKIP_CLR: begin
				skipNext = (fileVal & bitMask(bitSel)) == 8'h00;
			end
			eic_pkg::OP_SKIP_SET: begin
				skipNext = (fileVal & bitMask(bitSel)) != 8'h00;
			end
			eic_pkg::OP_COMP_FILE: begin
				result = ~fileVal;
				zeroUpd = 1'b1;
			end
			eic_pkg::OP_DEC_FILE: begin
				result = fileVal - 8'h01;
				zeroUpd = 1'b1;
			end
			eic_pkg::OP_CLR_FILE, eic_pkg::OP_CLR_ACC: begin
				result = 8'h00;
				zeroUpd = 1'b1;
			end
			eic_pkg::OP_DEC_SKIP: begin
				result = fileVal - 8'h01;
				skipNext = result == 8'h00;
			end
			eic_pkg::OP_INC_SKIP: begin
				result = fileVal + 8'h01;
				skipNext = result == 8'h00;
			end
			default: result = 8'h00;
		endcase
		zeroOut = result == 8'h00;
	end
endmodule : eic_alu
`default_nettype wire

// *** rtl/eic_stack.sv ***
// Return address stack of the execution core
`default_nettype none
`include "eic_cfg.svh"
module eic_stack (
	input wire logic mclk,
	input wire logic rst,
	input wire logic push,
	input wire logic [14:0] pushAddr,
	output logic [14:0] topAddr
);
	// Entries hold full counter width
	logic [14:0] entry [`EIC_STACK_DEPTH];
	logic [3:0] level; // Next free slot, wraps on overflow

	always_ff @(posedge mclk) begin
		if (rst) begin
			level <= 4'h0;
			for (int i = 0; i < `EIC_STACK_DEPTH; i++) begin
				entry[i] <= 15'h0000;
			end
		end else if (push) begin
			entry[level] <= pushAddr;
			level <= level + 4'h1;
		end
	end

	// Last pushed value
	assign topAddr = entry[level - 4'h1];
endmodule : eic_stack
`default_nettype wire

// *** rtl/eic_core.sv ***
// Instruction execution core with Avalon-MM state access
//
// Chosen here: the address map and the Avalon-MM slave port.
`default_nettype none
`include "eic_cfg.svh"
module eic_core (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [14:0] progAddr,
	input wire logic [13:0] progData,
	output logic [15:0] dataAddr,
	output logic dataRdEn,
	input wire logic [7:0] dataRdData,
	output logic [7:0] dataWrData,
	output logic dataWrEn
);
	// Decode one instruction word
	function automatic eic_pkg::eic_op_t decodeOp(input logic [13:0] w);
		eic_pkg::eic_op_t op;
		op = eic_pkg::OP_NOP;
		if (w == `EIC_OPC_BRANCH_ACC)
			op = eic_pkg::OP_BRANCH_ACC;
		else if (w == `EIC_OPC_CALL_ACC)
			op = eic_pkg::OP_CALL_ACC;
		else if (w == `EIC_OPC_WDOG_CLR)
			op = eic_pkg::OP_WDOG_CLR;
		else if (w[13:9] == `EIC_OPC_REL_BRANCH)
			op = eic_pkg::OP_REL_BRANCH;
		else if (w[13:11] == `EIC_OPC_CALL)
			op = eic_pkg::OP_CALL;
		else if (w[13:11] == `EIC_OPC_JUMP)
			op = eic_pkg::OP_JUMP;
		else if (w[13:7] == `EIC_OPC_PTR_ADD)
			op = eic_pkg::OP_PTR_ADD;
		else if (w[13:10] == `EIC_OPC_BIT_CLR)
			op = eic_pkg::OP_BIT_CLR;
		else if (w[13:10] == `EIC_OPC_BIT_SET)
			op = eic_pkg::OP_BIT_SET;
		else if (w[13:10] == `EIC_OPC_SKIP_CLR)
			op = eic_pkg::OP_SKIP_CLR;
		else if (w[13:10] == `EIC_OPC_SKIP_SET)
			op = eic_pkg::OP_SKIP_SET;
		else begin
			case (w[13:8])
				`EIC_OPC_ADD_FILE: op = eic_pkg::OP_ADD_FILE;
				`EIC_OPC_ADDC_FILE: op = eic_pkg::OP_ADDC_FILE;
				`EIC_OPC_AND_FILE: op = eic_pkg::OP_AND_FILE;
				`EIC_OPC_ASR_FILE: op = eic_pkg::OP_ASR_FILE;
				`EIC_OPC_COMP_FILE: op = eic_pkg::OP_COMP_FILE;
				`EIC_OPC_DEC_FILE: op = eic_pkg::OP_DEC_FILE;
				`EIC_OPC_DEC_SKIP: op = eic_pkg::OP_DEC_SKIP;
				`EIC_OPC_INC_SKIP: op = eic_pkg::OP_INC_SKIP;
				`EIC_OPC_ADD_LIT: op = eic_pkg::OP_ADD_LIT;
				`EIC_OPC_AND_LIT: op = eic_pkg::OP_AND_LIT;
				`EIC_OPC_OR_LIT: op = eic_pkg::OP_OR_LIT;
				`EIC_OPC_CLEAR: op = w[7] ? eic_pkg::OP_CLR_FILE :
					eic_pkg::OP_CLR_ACC;
				default: op = eic_pkg::OP_NOP;
			endcase
		end
		decodeOp = op;
	endfunction : decodeOp

	// Operation touches a file register
	function automatic logic isFileOp(input eic_pkg::eic_op_t op);
		case (op)
			eic_pkg::OP_AND_FILE, eic_pkg::OP_ADD_FILE,
			eic_pkg::OP_ADDC_FILE, eic_pkg::OP_ASR_FILE,
			eic_pkg::OP_BIT_CLR, eic_pkg::OP_BIT_SET,
			eic_pkg::OP_SKIP_CLR, eic_pkg::OP_SKIP_SET,
			eic_pkg::OP_COMP_FILE, eic_pkg::OP_CLR_FILE,
			eic_pkg::OP_DEC_FILE, eic_pkg::OP_DEC_SKIP,
			eic_pkg::OP_INC_SKIP: isFileOp = 1'b1;
			default: isFileOp = 1'b0;
		endcase
	endfunction : isFileOp

	// Byte-lane merge of a bus write into a 16-bit pointer
	function automatic logic [15:0] laneMerge(input logic [15:0] old,
			input logic [31:0] wdata, input logic [3:0] be);
		logic [15:0] m;
		m = old;
		// Upper lanes have no pointer bits behind them
		for (int i = 0; i < 2; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		laneMerge = m;
	endfunction : laneMerge

	eic_pkg::eic_phase_t phaseReg; // Phase within the cycle
	eic_pkg::eic_phase_t phaseNext;
	logic runReg; // Software run enable
	logic [6:0] hLatchReg; // program_counter_high_latch
	logic [14:0] pcReg; // Address of current instruction
	logic [14:0] pcNext;
	logic [13:0] instrReg; // Instruction being executed
	logic [7:0] accReg; // Accumulator
	logic carryReg; // Carry flag
	logic digitReg; // digit_carry_flag
	logic zeroReg; // Zero flag
	logic [15:0] ptrReg [2]; // indirect_pointer pair per index
	logic [7:0] fileValReg; // File operand read in phase three
	logic [1:0] flushReg; // No-op instruction cycles still owed
	logic [7:0] prescaleReg; // Watchdog prescaler
	logic [7:0] wdogReg; // watchdog_counter
	logic timeoutFlagNReg; // timeout_flag_n
	logic powerDownFlagNReg; // power_down_flag_n
	logic waitReg; // Bus wait state
	logic [31:0] readReg; // Bus read data

	eic_pkg::eic_op_t curOp; // Decoded current instruction
	eic_pkg::eic_op_t fetchOp; // Decoded word on the program bus
	logic isExec; // Real instruction in its last phase
	logic [7:0] aluResult;
	logic aluCarry, aluDigit, aluZero;
	logic updC, updDig, updZ, skipNext;
	logic toAcc; // Result goes to accumulator
	logic toFile; // Result goes to file register
	logic twoCycle; // Counter redirected or skip taken
	logic slowIndirect; // Pointer aims at program memory
	logic doPush; // Stack push this cycle
	logic [14:0] pcPlus1;
	logic [14:0] stackTop;
	logic busWrite; // Bus write takes effect this edge
	logic [6:0] fetchFile; // File field of fetched word

	assign curOp = decodeOp(instrReg);
	assign fetchOp = decodeOp(progData);
	assign fetchFile = progData[6:0];
	assign isExec = phaseReg == eic_pkg::PH_EXEC && flushReg == 2'h0;
	assign pcPlus1 = pcReg + 15'h0001;
	assign busWrite = avs_write && !waitReg;

	eic_alu aluInst (
		.op(curOp),
		.acc(accReg),
		.fileVal(fileValReg),
		.lit(instrReg[7:0]),
		.carryIn(carryReg),
		.bitSel(instrReg[9:7]),
		.result(aluResult),
		.carryOut(aluCarry),
		.digitOut(aluDigit),
		.zeroOut(aluZero),
		.carryUpd(updC),
		.digitUpd(updDig),
		.zeroUpd(updZ),
		.skipNext(skipNext)
	);

	eic_stack stackInst (
		.mclk(mclk),
		.rst(rst),
		.push(doPush),
		.pushAddr(pcPlus1),
		.topAddr(stackTop)
	);

	// Destination routing
	always_comb begin
		toAcc = 1'b0;
		toFile = 1'b0;
		case (curOp)
			eic_pkg::OP_AND_LIT, eic_pkg::OP_ADD_LIT,
			eic_pkg::OP_OR_LIT, eic_pkg::OP_CLR_ACC: toAcc = 1'b1;
			eic_pkg::OP_CLR_FILE, eic_pkg::OP_BIT_CLR,
			eic_pkg::OP_BIT_SET: toFile = 1'b1;
			eic_pkg::OP_AND_FILE, eic_pkg::OP_ADD_FILE,
			eic_pkg::OP_ADDC_FILE, eic_pkg::OP_ASR_FILE,
			eic_pkg::OP_COMP_FILE, eic_pkg::OP_DEC_FILE,
			eic_pkg::OP_DEC_SKIP, eic_pkg::OP_INC_SKIP: begin
				toAcc = !instrReg[7];
				toFile = instrReg[7];
			end
			default: toAcc = 1'b0;
		endcase
	end

	// Next program counter
	always_comb begin
		pcNext = pcPlus1;
		twoCycle = 1'b1;
		case (curOp)
			eic_pkg::OP_REL_BRANCH: begin
				pcNext = pcPlus1 + {{6{instrReg[8]}}, instrReg[8:0]};
			end
			eic_pkg::OP_BRANCH_ACC: pcNext = pcPlus1 + {7'h00, accReg};
			eic_pkg::OP_CALL, eic_pkg::OP_JUMP: begin
				pcNext = {hLatchReg[6:3], instrReg[10:0]};
			end
			eic_pkg::OP_CALL_ACC: pcNext = {hLatchReg, accReg};
			default: begin
				pcNext = skipNext ? pcReg + 15'h0002 : pcPlus1;
				twoCycle = skipNext;
			end
		endcase
	end

	assign slowIndirect = isFileOp(curOp) && instrReg[6:1] == 6'h00 &&
		ptrReg[instrReg[0]][15];
	assign doPush = isExec && (curOp == eic_pkg::OP_CALL ||
		curOp == eic_pkg::OP_CALL_ACC);

	always_comb begin
		case (phaseReg)
			eic_pkg::PH_ADDR: phaseNext = runReg ? eic_pkg::PH_LATCH :
				eic_pkg::PH_ADDR;
			eic_pkg::PH_LATCH: phaseNext = eic_pkg::PH_READ;
			eic_pkg::PH_READ: phaseNext = eic_pkg::PH_EXEC;
			default: phaseNext = eic_pkg::PH_ADDR;
		endcase
	end

	// Phase register
	always_ff @(posedge mclk) begin
		if (rst) begin
			phaseReg <= eic_pkg::PH_ADDR;
		end else begin
			phaseReg <= phaseNext;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			instrReg <= 14'h0000;
		end else if (phaseReg == eic_pkg::PH_LATCH) begin
			// Flush cycles run a no-op in place of the word
			instrReg <= (flushReg == 2'h0) ? progData : 14'h0000;
		end
	end

	// Owed no-op cycles; counter holds the address during them
	always_ff @(posedge mclk) begin
		if (rst) begin
			flushReg <= 2'h0;
		end else if (phaseReg == eic_pkg::PH_EXEC) begin
			if (flushReg != 2'h0) begin
				flushReg <= flushReg - 2'h1;
			end else begin
				flushReg <= {1'b0, twoCycle} + {1'b0, slowIndirect};
			end
		end
	end

	// Program counter and fetch address
	always_ff @(posedge mclk) begin
		if (rst) begin
			pcReg <= `EIC_RST_PC;
			progAddr <= `EIC_RST_PC;
		end else if (isExec) begin
			pcReg <= pcNext;
			progAddr <= pcNext;
		end
	end

	// File read address and strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			dataAddr <= 16'h0000;
			dataRdEn <= 1'b0;
		end else if (phaseReg == eic_pkg::PH_LATCH) begin
			// Indirect slots 0 and 1 follow the pointer
			dataAddr <= (fetchFile[6:1] == 6'h00) ? ptrReg[fetchFile[0]] :
				{9'h000, fetchFile};
			dataRdEn <= flushReg == 2'h0 && isFileOp(fetchOp);
		end else begin
			dataRdEn <= 1'b0;
		end
	end

	// File operand capture
	always_ff @(posedge mclk) begin
		if (rst) begin
			fileValReg <= 8'h00;
		end else if (phaseReg == eic_pkg::PH_READ) begin
			fileValReg <= dataRdData;
		end
	end

	// Write-back lands one phase later, address still held
	always_ff @(posedge mclk) begin
		if (rst) begin
			dataWrEn <= 1'b0;
			dataWrData <= 8'h00;
		end else if (isExec && toFile) begin
			dataWrEn <= 1'b1;
			dataWrData <= aluResult;
		end else begin
			dataWrEn <= 1'b0;
		end
	end

	// Accumulator and status flags
	always_ff @(posedge mclk) begin
		if (rst) begin
			accReg <= 8'h00;
			carryReg <= 1'b0;
			digitReg <= 1'b0;
			zeroReg <= 1'b0;
		end else if (isExec) begin
			if (toAcc) begin
				accReg <= aluResult;
			end
			if (updC) begin
				carryReg <= aluCarry;
			end
			if (updDig) begin
				digitReg <= aluDigit;
			end
			if (updZ) begin
				zeroReg <= aluZero;
			end
		end
	end

	// Indirect pointers: bus write first, then pointer add
	always_ff @(posedge mclk) begin
		if (rst) begin
			ptrReg[0] <= 16'h0000;
			ptrReg[1] <= 16'h0000;
		end else if (busWrite && avs_address == `EIC_REG_PTR0) begin
			ptrReg[0] <= laneMerge(ptrReg[0], avs_writedata,
				avs_byteenable);
		end else if (busWrite && avs_address == `EIC_REG_PTR1) begin
			ptrReg[1] <= laneMerge(ptrReg[1], avs_writedata,
				avs_byteenable);
		end else if (isExec && curOp == eic_pkg::OP_PTR_ADD) begin
			ptrReg[instrReg[6]] <= ptrReg[instrReg[6]] +
				{{10{instrReg[5]}}, instrReg[5:0]};
		end
	end

	// Watchdog; a timeout in the clear cycle still wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			prescaleReg <= 8'h00;
			wdogReg <= 8'h00;
			timeoutFlagNReg <= `EIC_RST_FLAGN;
			powerDownFlagNReg <= `EIC_RST_FLAGN;
		end else begin
			prescaleReg <= prescaleReg + 8'h01;
			if (prescaleReg == `EIC_PRESCALE_MAX) begin
				wdogReg <= wdogReg + 8'h01;
			end
			if (isExec && curOp == eic_pkg::OP_WDOG_CLR) begin
				prescaleReg <= 8'h00;
				wdogReg <= 8'h00;
				timeoutFlagNReg <= 1'b1;
				powerDownFlagNReg <= 1'b1;
			end
			if (prescaleReg == `EIC_PRESCALE_MAX &&
					wdogReg == `EIC_PRESCALE_MAX) begin
				timeoutFlagNReg <= 1'b0;
			end
		end
	end

	// Control registers written by software
	always_ff @(posedge mclk) begin
		if (rst) begin
			runReg <= 1'b0;
			hLatchReg <= 7'h00;
		end else if (busWrite && avs_byteenable[0]) begin
			if (avs_address == `EIC_REG_CTRL) begin
				runReg <= avs_writedata[`EIC_CTRL_RUN];
			end
			if (avs_address == `EIC_REG_HLATCH) begin
				hLatchReg <= avs_writedata[6:0];
			end
		end
	end

	// One wait cycle per access, then ready for one edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			waitReg <= 1'b1;
		end else begin
			waitReg <= !((avs_read || avs_write) && waitReg);
		end
	end

	// Read data loaded during the wait cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			readReg <= 32'h00000000;
		end else if (avs_read && waitReg) begin
			case (avs_address)
				`EIC_REG_CTRL: readReg <= {31'h00000000, runReg};
				`EIC_REG_HLATCH: readReg <= {25'h0000000, hLatchReg};
				`EIC_REG_STATUS: readReg <= {27'h0000000, timeoutFlagNReg,
					powerDownFlagNReg, zeroReg, digitReg, carryReg};
				`EIC_REG_ACC: readReg <= {24'h000000, accReg};
				`EIC_REG_PC: readReg <= {17'h00000, pcReg};
				`EIC_REG_PTR0: readReg <= {16'h0000, ptrReg[0]};
				`EIC_REG_PTR1: readReg <= {16'h0000, ptrReg[1]};
				`EIC_REG_WDOG: readReg <= {24'h000000, wdogReg};
				`EIC_REG_STKTOP: readReg <= {17'h00000, stackTop};
				default: readReg <= 32'h00000000;
			endcase
		end
	end

	assign avs_readdata = readReg;
	assign avs_waitrequest = waitReg;
endmodule : eic_core
`default_nettype wire

// *** verification/eic_core_properties.sv ***
// Port-level timing checks for the execution core
`default_nettype none
module eic_core_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [14:0] progAddr,
	input wire logic [15:0] dataAddr,
	input wire logic dataRdEn,
	input wire logic dataWrEn
);
	timeunit 1ns;
	timeprecision 1ns;
	// All checks share the core clock and reset
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// Request answered after exactly one cycle
	property p_ack_one;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("late bus answer");
	// Acknowledge lasts a single cycle
	property p_ack_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
	// No answer without a request
	property p_no_spur;
		!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_no_spur: assert property (p_no_spur) else $error("spurious ack");
	// Clean state right after reset release
	property p_rst_vals;
		$fell(rst) |-> avs_waitrequest && progAddr == 15'h0000 && !dataWrEn;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset state");
	// Program address held for a whole cycle
	property p_pc_hold;
		$changed(progAddr) |=> $stable(progAddr) [*3];
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc moved early");
	// Read strobe is a one-cycle pulse
	property p_rd_pulse;
		dataRdEn |=> !dataRdEn && $stable(dataAddr);
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe");
	// Write-back follows its read two cycles on
	property p_wr_after_rd;
		dataWrEn |-> $past(dataRdEn, 2) && $stable(dataAddr);
	endproperty
	a_wr_after_rd: assert property (p_wr_after_rd) else $error("stray write");
	// Write strobe is a one-cycle pulse
	property p_wr_pulse;
		dataWrEn |=> !dataWrEn;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe");
	c_write: cover property (dataWrEn);
	c_read_ack: cover property (avs_read && !avs_waitrequest);
	c_pc_move: cover property ($changed(progAddr));
endmodule : eic_core_properties
`default_nettype wire

// *** verification/eic_mem_model.sv ***
// Program memory and data register file beside the core
`default_nettype none
module eic_mem_model (
	input wire logic mclk,
	input wire logic [14:0] progAddr,
	output logic [13:0] progData,
	input wire logic [15:0] dataAddr,
	input wire logic dataRdEn,
	output logic [7:0] dataRdData,
	input wire logic [7:0] dataWrData,
	input wire logic dataWrEn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [13:0] prog [0:127]; // Aliases every 128 words
	logic [7:0] data [0:255]; // Small file, low address bits
	assign progData = prog[progAddr[6:0]];
	// Unselected reads show inverse, never stale data
	assign dataRdData = dataRdEn ? data[dataAddr[7:0]] : ~data[dataAddr[7:0]];
	always @(posedge mclk) begin
		if (dataWrEn) data[dataAddr[7:0]] <= dataWrData;
	end
endmodule : eic_mem_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the execution core
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst, avs_read, avs_write, avs_waitrequest, dataRdEn, dataWrEn;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [14:0] progAddr;
	logic [13:0] progData;
	logic [15:0] dataAddr;
	logic [7:0] dataRdData, dataWrData;
	int num_errors = 0;
	int n_tests = 0;
	eic_core u_dut (.mclk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.progAddr, .progData, .dataAddr, .dataRdEn, .dataRdData,
		.dataWrData, .dataWrEn);
	eic_mem_model u_mem (.mclk, .progAddr, .progData, .dataAddr, .dataRdEn,
		.dataRdData, .dataWrData, .dataWrEn);
	// 100 ns period
	always #50 mclk = ~mclk;
	task automatic finish_test();
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One Avalon access; an edge passes first so strobes never collide
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		i = 0;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			if (++i > 20) begin
				num_errors++;
				finish_test();
			end
			@(posedge mclk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	// Reset values, read-only and unmapped places
	task automatic t_regs();
		bus(1'b0, 6'h10, 32'h0);
		chk("pc_reset", q & 32'h7fff, 32'h0);
		bus(1'b1, 6'h08, 32'h0);
		bus(1'b0, 6'h08, 32'h0);
		chk("status_ro", q & 32'h18, 32'h18);
		bus(1'b1, 6'h3c, 32'hffffffff);
		bus(1'b0, 6'h3c, 32'h0);
		chk("unmapped", q, 32'h0);
	endtask : t_regs
	// Program run covering arithmetic, skips, call, jump and pointer add
	task automatic t_program();
		int i;
		bus(1'b1, 6'h14, 32'h0);
		bus(1'b1, 6'h04, 32'h08);
		bus(1'b1, 6'h00, 32'h1);
		i = 0;
		while (progAddr !== 15'h0830) begin
			if (++i > 2000) begin
				num_errors++;
				finish_test();
			end
			@(posedge mclk);
		end
		repeat (8) @(posedge mclk);
		bus(1'b0, 6'h0c, 32'h0);
		chk("acc", q & 32'hff, 32'h0a);
		bus(1'b0, 6'h08, 32'h0);
		chk("status", q & 32'h1f, 32'h19);
		bus(1'b0, 6'h10, 32'h0);
		chk("pc", q & 32'h7fff, 32'h0830);
		bus(1'b0, 6'h20, 32'h0);
		chk("stack_top", q & 32'h7fff, 32'h000d);
		bus(1'b0, 6'h14, 32'h0);
		chk("ptr0", q & 32'hffff, 32'hffff);
		chk("add_dest_f", u_mem.data[8'h20], 8'h00);
		chk("addc_dest_w", u_mem.data[8'h21], 8'h05);
		chk("asr_bclr", u_mem.data[8'h22], 8'h40);
		chk("dec_skip", u_mem.data[8'h23], 8'h00);
		chk("comp_dest_w", u_mem.data[8'h24], 8'h55);
		chk("bit_skip", u_mem.data[8'h25], 8'h5a);
		chk("zero_skip", u_mem.data[8'h27], 8'h5a);
		chk("bit_set", u_mem.data[8'h26], 8'h01);
	endtask : t_program
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		for (int i = 0; i < 256; i++) begin
			u_mem.data[i] = 8'h00;
			if (i < 128) u_mem.prog[i] = 14'h0000;
		end
		// Clear, OR, add, add to file, add with carry
		u_mem.prog[0] = 14'h0100;
		u_mem.prog[1] = {6'h38, 8'h0f};
		u_mem.prog[2] = {6'h3e, 8'h01};
		u_mem.prog[3] = {6'h07, 1'b1, 7'h20};
		u_mem.prog[4] = {6'h3d, 1'b0, 7'h21};
		// Shift, bit clear, taken skips over clears
		u_mem.prog[5] = {6'h37, 1'b1, 7'h22};
		u_mem.prog[6] = {4'h4, 3'h7, 7'h22};
		u_mem.prog[7] = {4'h7, 3'h6, 7'h22};
		u_mem.prog[8] = {6'h01, 1'b1, 7'h25};
		u_mem.prog[9] = {6'h0b, 1'b1, 7'h23};
		u_mem.prog[10] = {6'h01, 1'b1, 7'h27};
		// Complement to accumulator, call, pointer add, AND literal
		u_mem.prog[11] = {6'h09, 1'b0, 7'h24};
		u_mem.prog[12] = {3'h4, 11'h020};
		u_mem.prog[32] = {7'h62, 1'b0, 6'h3f};
		u_mem.prog[33] = {6'h39, 8'h0f};
		// Relative branch and branch by accumulator over clears
		u_mem.prog[34] = {5'h19, 9'h001};
		u_mem.prog[35] = 14'h0100;
		u_mem.prog[36] = 14'h000b;
		u_mem.prog[37] = 14'h0100;
		u_mem.prog[46] = 14'h0100;
		// Bit set, then jump to self
		u_mem.prog[47] = {4'h5, 3'h0, 7'h26};
		u_mem.prog[48] = {3'h5, 11'h030};
		u_mem.data[8'h20] = 8'hf0;
		u_mem.data[8'h21] = 8'h05;
		u_mem.data[8'h22] = 8'h81;
		u_mem.data[8'h23] = 8'h01;
		u_mem.data[8'h24] = 8'h55;
		u_mem.data[8'h25] = 8'h5a;
		u_mem.data[8'h27] = 8'h5a;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_program();
		finish_test();
	end
endmodule : testbench
bind eic_core eic_core_properties u_props (.mclk, .rst, .avs_read,
	.avs_write, .avs_waitrequest, .progAddr, .dataAddr, .dataRdEn,
	.dataWrEn);
`default_nettype wire
